/* svs_vib_suppress.sv */
// Purpose: Torque reference vibration suppression with notch, IF and load paths
// Assumes: One sample per accepted trqIn word; selectors read once after reset
// Notes: Filter coefficients are simple first-order approximations
`timescale 1ns/1ps

module svs_notch #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Sample stream
	input wire logic adv,
	input wire logic vIn,
	input wire logic signed [W-1:0] x,
	output logic vOut,
	output logic signed [W-1:0] y,
	// Settings
	input wire logic [15:0] freq,
	input wire logic [4:0] depth,
	input wire logic [3:0] width
);
	import svs_pkg::*;
	logic signed [31:0] lp_q;
	logic signed [47:0] diff;
	logic signed [47:0] step;
	logic signed [47:0] atten;

	always_comb begin
		diff = 48'(x) - 48'(lp_q);
		step = (diff * $signed({1'b0, freq}) * $signed({1'b0, width} + 6'sh1)) >>> NOTCH_RATE_SH;
		atten = (diff * $signed({1'b0, ATTEN_BASE - {1'b0, depth}})) >>> ATTEN_SH;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lp_q <= '0;
		end else if (adv && vIn) begin
			lp_q <= 32'(48'(lp_q) + step);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vOut <= 1'b0;
			y <= '0;
		end else if (adv) begin
			vOut <= vIn;
			if (freq == NOTCH_OFF)
				y <= x;
			else
				y <= svsSat(48'(x) - atten);
		end
	end

	chk_notch_bypass: assert property (@(posedge clk) disable iff (!resetn)
		(adv && freq == NOTCH_OFF) |=> y == $past(x))
		else $error("disabled notch altered data");
endmodule

module svs_vib_suppress (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Torque reference in and speed deviation in
	input wire logic signed [svs_pkg::DATA_W-1:0] trqIn,
	input wire logic trqInValid,
	output logic trqInReady,
	input wire logic signed [svs_pkg::DATA_W-1:0] spdDev,
	// Torque reference out
	output logic signed [svs_pkg::DATA_W-1:0] trqOut,
	output logic trqOutValid,
	input wire logic trqOutReady,
	// Notch settings
	input wire logic [15:0] notch1_freq,
	input wire logic [4:0] notch1_depth,
	input wire logic [3:0] notch1_width,
	input wire logic [15:0] notch2_freq,
	input wire logic [4:0] notch2_depth,
	input wire logic [3:0] notch2_width,
	input wire logic [15:0] notch3_freq,
	input wire logic [4:0] notch3_depth,
	input wire logic [3:0] notch3_width,
	// IF settings
	input wire logic [15:0] if_center_freq,
	input wire logic [15:0] if_bandwidth,
	input wire logic [15:0] if_suppression,
	input wire logic [15:0] if_lowpass_time,
	input wire logic [15:0] if_highpass_time,
	input wire logic [15:0] if_damping,
	// Load oscillation settings and mode
	input wire logic [1:0] model_follow_select,
	input wire logic [15:0] load_osc_freq,
	input wire logic [15:0] load_osc_filter_time,
	input wire logic [31:0] load_osc_limit,
	input wire logic posCtrlMode,
	input wire logic manualTuning,
	input wire logic fullyClosed,
	// Model-following terms
	input wire logic signed [svs_pkg::POS_W-1:0] posRefIn,
	input wire logic signed [svs_pkg::POS_W-1:0] speedFfIn,
	input wire logic signed [svs_pkg::POS_W-1:0] torqueFfIn,
	input wire logic signed [svs_pkg::POS_W-1:0] loadPos,
	input wire logic signed [svs_pkg::POS_W-1:0] motorPos,
	output logic signed [svs_pkg::POS_W-1:0] posRefOut,
	output logic signed [svs_pkg::POS_W-1:0] speedFfOut,
	output logic signed [svs_pkg::POS_W-1:0] torqueFfOut,
	output logic losActive,
	// Automatic detection
	input wire logic auto_vib_enable,
	input wire logic [15:0] vib_amplitude_threshold,
	input wire logic detValid,
	input wire logic [15:0] detFreq,
	input wire logic [15:0] detAmp,
	output logic vibDetected,
	output logic autoNotchSet,
	output logic autoIfSet,
	output logic [15:0] autoFreq
);
	import svs_pkg::*;
	svs_state_e state_q;
	logic [1:0] mfSel_q;
	logic autoEn_q;
	logic take;
	logic [4:0] depth_q [3];
	logic [3:0] width_q [3];
	logic [4:0] depthIn [3];
	logic [3:0] widthIn [3];
	logic [15:0] freqEff [3];
	logic [15:0] ifCenter;
	logic ifEn;
	logic signed [31:0] hpLp_q, lp_q, bpLp_q;
	logic signed [47:0] hpOut, bpOut, ifRaw;
	logic signed [15:0] ifComp_q;
	logic signed [DATA_W-1:0] sum_q;
	logic sumV_q;
	logic v [4];
	logic signed [DATA_W-1:0] d [4];
	logic signed [31:0] losFilt_q, losCorr_q;
	logic signed [47:0] losRaw;
	logic losAct;
	logic signed [DATA_W-1:0] spare_q;
	logic spareV_q, outVd, spareVd, pop, push;

	assign take = trqInValid && trqInReady;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_RESTART;
			mfSel_q <= MF_OFF;
			autoEn_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_RESTART: begin
					mfSel_q <= model_follow_select;
					autoEn_q <= auto_vib_enable;
					state_q <= ST_RUN;
				end
				ST_RUN: begin
				end
			endcase
		end
	end

	assign depthIn = '{notch1_depth, notch2_depth, notch3_depth};
	assign widthIn = '{notch1_width, notch2_width, notch3_width};
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			depth_q <= '{DEPTH_RST, DEPTH_RST, DEPTH_RST};
			width_q <= '{WIDTH_RST, WIDTH_RST, WIDTH_RST};
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (depthIn[i] <= DEPTH_MAX)
					depth_q[i] <= depthIn[i];
				if (widthIn[i] <= WIDTH_MAX)
					width_q[i] <= widthIn[i];
			end
		end
	end

	// detected frequency overrides notch 2 or IF centre
	assign freqEff[0] = notch1_freq;
	assign freqEff[1] = autoNotchSet ? autoFreq : notch2_freq;
	assign freqEff[2] = notch3_freq;
	assign ifCenter = autoIfSet ? autoFreq : if_center_freq;
	assign ifEn = (ifCenter >= IF_MIN) && (ifCenter < IF_MAX) && (ifCenter != IF_OFF);

	always_comb begin
		hpOut = 48'(spdDev) - 48'(hpLp_q);
		// band edge from centre and bandwidth
		bpOut = 48'(lp_q) - 48'(bpLp_q);
		ifRaw = (bpOut * $signed({1'b0, if_damping}) * $signed({1'b0, if_suppression})) >>> IF_GAIN_SH;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hpLp_q <= '0;
			lp_q <= '0;
			bpLp_q <= '0;
			ifComp_q <= '0;
		end else if (take) begin
			hpLp_q <= hpLp_q + ((32'(spdDev) - hpLp_q) >>> svsShift(if_highpass_time));
			lp_q <= lp_q + 32'((hpOut - 48'(lp_q)) >>> svsShift(if_lowpass_time));
			bpLp_q <= bpLp_q + 32'((bpOut * $signed({1'b0, ifCenter})
				* $signed({1'b0, if_bandwidth[7:0]} + 10'sh1)) >>> IF_BAND_SH);
			ifComp_q <= ifEn ? svsSat(ifRaw) : 16'sh0000;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sum_q <= '0;
			sumV_q <= 1'b0;
		end else if (trqInReady) begin
			sumV_q <= trqInValid;
			sum_q <= svsSat(48'(trqIn) + 48'(ifComp_q));
		end
	end

	assign v[0] = sumV_q;
	assign d[0] = sum_q;
	// three notches in series; one step per sample
	for (genvar g = 0; g < 3; g++) begin : gNotch
		svs_notch #(.W(DATA_W)) uNotch (
			.clk(clk),
			.resetn(resetn),
			.adv(trqInReady),
			.vIn(v[g]),
			.x(d[g]),
			.vOut(v[g+1]),
			.y(d[g+1]),
			.freq(freqEff[g]),
			.depth(depth_q[g]),
			.width(width_q[g])
		);
	end

	// Two-entry skid buffer so a stalled receiver loses no word
	assign push = v[3] && trqInReady;
	assign pop = trqOutValid && trqOutReady;
	always_comb begin
		outVd = trqOutValid;
		spareVd = spareV_q;
		if (pop || !trqOutValid) begin
			outVd = spareV_q || push;
			spareVd = spareV_q && push;
		end else if (push) begin
			spareVd = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			trqOut <= '0;
			trqOutValid <= 1'b0;
			spare_q <= '0;
			spareV_q <= 1'b0;
			trqInReady <= 1'b0;
		end else begin
			trqOutValid <= outVd;
			spareV_q <= spareVd;
			// Ready stalls the whole pipe, so nothing is dropped
			trqInReady <= !(outVd && spareVd);
			if (pop || !trqOutValid) begin
				if (spareV_q) begin
					trqOut <= spare_q;
					spare_q <= d[3];
				end else begin
					trqOut <= d[3];
				end
			end else if (push) begin
				spare_q <= d[3];
			end
		end
	end

	// mode gating; fully closed blocks; 0/1 inactive
	assign losAct = (mfSel_q == MF_LOS) && posCtrlMode && manualTuning && !fullyClosed;
	assign losRaw = (48'(losFilt_q) * $signed({1'b0, load_osc_freq})) >>> LOS_FREQ_SH;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			losFilt_q <= '0;
			losCorr_q <= '0;
			losActive <= 1'b0;
		end else begin
			losActive <= losAct;
			if (!losAct) begin
				losFilt_q <= '0;
				losCorr_q <= '0;
			end else if (take) begin
				losFilt_q <= losFilt_q + (((loadPos - motorPos) - losFilt_q)
					>>> svsShift(load_osc_filter_time));
				if (losRaw > 48'($signed({1'b0, load_osc_limit})))
					losCorr_q <= $signed(load_osc_limit);
				else if (losRaw < -48'($signed({1'b0, load_osc_limit})))
					losCorr_q <= -$signed(load_osc_limit);
				else
					losCorr_q <= losRaw[31:0];
			end
		end
	end

	// correction applied to reference and feedforward
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			posRefOut <= '0;
			speedFfOut <= '0;
			torqueFfOut <= '0;
		end else begin
			posRefOut <= posRefIn - losCorr_q;
			speedFfOut <= speedFfIn - losCorr_q;
			torqueFfOut <= torqueFfIn - losCorr_q;
		end
	end

	// threshold test; path choice by frequency band
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vibDetected <= 1'b0;
			autoNotchSet <= 1'b0;
			autoIfSet <= 1'b0;
			autoFreq <= '0;
		end else begin
			vibDetected <= 1'b0;
			if (autoEn_q && state_q == ST_RUN && detValid && detAmp > vib_amplitude_threshold) begin
				vibDetected <= 1'b1;
				autoFreq <= detFreq;
				autoIfSet <= (detFreq >= IF_MIN) && (detFreq < IF_MAX);
				autoNotchSet <= !((detFreq >= IF_MIN) && (detFreq < IF_MAX));
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	chk_depth_legal: assert property (depth_q[0] <= DEPTH_MAX
		&& depth_q[1] <= DEPTH_MAX && depth_q[2] <= DEPTH_MAX)
		else $error("notch depth out of range");
	chk_width_range: assert property ($changed(width_q[0])
		|-> width_q[0] == $past(notch1_width))
		else $error("notch width not taken as set");
	chk_if_off: assert property ((take && ifCenter == IF_OFF) |=> ifComp_q == 16'sh0000)
		else $error("IF compensation while disabled");
	chk_if_band: assert property ((take && ifCenter < IF_MIN) |=> ifComp_q == 16'sh0000)
		else $error("IF compensation below band");
	chk_los_select: assert property (losActive |-> mfSel_q == MF_LOS && $past(posCtrlMode))
		else $error("load suppression without selector 2");
	chk_los_closed: assert property (fullyClosed |=> !losActive && losCorr_q == 32'sh0)
		else $error("load suppression in fully closed loop");
	chk_los_clamp: assert property ($changed(losCorr_q) && losActive
		|-> losCorr_q <= $signed({1'b0, $past(load_osc_limit)}))
		else $error("load correction over limit");
	chk_vib_thresh: assert property (vibDetected
		|-> $past(detAmp) > $past(vib_amplitude_threshold) && $past(autoEn_q))
		else $error("vibration declared below threshold");
	chk_buf_hold: assert property ((trqOutValid && !trqOutReady)
		|=> trqOutValid && $stable(trqOut))
		else $error("output word lost under stall");

	cov_stall: cover property (trqOutValid && !trqOutReady ##1 !trqInReady);
	cov_auto_if: cover property (vibDetected ##1 autoIfSet);
	cov_los_on: cover property (losActive && $changed(losCorr_q));
	cov_notch_live: cover property (push && freqEff[0] != NOTCH_OFF);
endmodule

/* svs_pkg.sv */
// Purpose: Shared constants and helpers for the vibration suppression stage
// Assumes: Frequencies are integer Hz, load oscillation frequency in 0.1 Hz
// Notes: Shift helpers map a time setting onto a first-order filter rate
package svs_pkg;
	localparam int DATA_W = 16;
	localparam int POS_W = 32;
	localparam int FREQ_W = 16;
	localparam logic [15:0] NOTCH_OFF = 16'h1388;
	localparam logic [4:0] DEPTH_MAX = 5'h17;
	localparam logic [3:0] WIDTH_MAX = 4'hf;
	localparam logic [4:0] DEPTH_RST = 5'h00;
	localparam logic [3:0] WIDTH_RST = 4'h0;
	localparam logic [5:0] ATTEN_BASE = 6'h18;
	localparam int NOTCH_RATE_SH = 17;
	localparam int ATTEN_SH = 5;
	localparam logic [15:0] IF_OFF = 16'h07d0;
	localparam logic [15:0] IF_MIN = 16'h0064;
	localparam logic [15:0] IF_MAX = 16'h07d0;
	localparam int IF_BAND_SH = 18;
	localparam int IF_GAIN_SH = 16;
	localparam int LOS_FREQ_SH = 10;
	localparam logic [1:0] MF_OFF = 2'h0;
	localparam logic [1:0] MF_ON = 2'h1;
	localparam logic [1:0] MF_LOS = 2'h2;
	typedef enum logic {
		ST_RESTART = 1'b0,
		ST_RUN = 1'b1
	} svs_state_e;
	function automatic logic signed [15:0] svsSat(input logic signed [47:0] v);
		if (v > 48'sh7fff)
			return 16'sh7fff;
		else if (v < -48'sh8000)
			return -16'sh8000;
		else
			return v[15:0];
	endfunction
	// Time settings above 15 saturate to the slowest filter
	function automatic logic [3:0] svsShift(input logic [15:0] t);
		return (|t[15:4]) ? 4'hf : t[3:0];
	endfunction
endpackage

/* svs_torque_sink.sv */
// Purpose: Downstream torque stage model that collects filtered torque words
// Assumes: Ready moves just after the rising edge, as a registered stage would
// Notes: Stall holds ready low, so the block under test must buffer
`timescale 1ns/1ps

module svs_torque_sink (
	// Clock
	input wire logic clk,
	// Torque stream
	input wire logic signed [svs_pkg::DATA_W-1:0] trqOut,
	input wire logic trqOutValid,
	output logic trqOutReady,
	// Control from the bench
	input wire logic stall
);
	import svs_pkg::*;
	logic signed [DATA_W-1:0] got[$];
	initial trqOutReady = 1'b0;
	always @(posedge clk) begin
		trqOutReady <= !stall;
		if (trqOutValid === 1'b1 && trqOutReady === 1'b1)
			got.push_back(trqOut);
	end
endmodule

/* tb_top.sv */
// Purpose: Self-checking bench for the vibration suppression stage
// Assumes: Inputs move on the falling edge; selectors latch after reset
// Notes: Filter values are not predicted, only bypass, stall order, gating and detection
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin samplesChecked++; if ((sn) !== (ex)) begin errorCnt++; \
	$display("BAD %s exp %0h got %0h", nm, ex, sn); end end

module tb_top;
	import svs_pkg::*;
	logic clk, resetn, stall, trqInValid, trqInReady, trqOutValid, trqOutReady;
	logic signed [DATA_W-1:0] trqIn, spdDev, trqOut;
	logic [15:0] notch1_freq, notch2_freq, notch3_freq, if_center_freq, if_bandwidth;
	logic [15:0] if_suppression, if_lowpass_time, if_highpass_time, if_damping;
	logic [15:0] load_osc_freq, load_osc_filter_time, vib_amplitude_threshold;
	logic [15:0] detFreq, detAmp, autoFreq;
	logic [4:0] notch1_depth, notch2_depth, notch3_depth;
	logic [3:0] notch1_width, notch2_width, notch3_width;
	logic [1:0] model_follow_select;
	logic [31:0] load_osc_limit;
	logic posCtrlMode, manualTuning, fullyClosed, losActive, auto_vib_enable, detValid;
	logic vibDetected, autoNotchSet, autoIfSet;
	logic signed [POS_W-1:0] posRefIn, speedFfIn, torqueFfIn, loadPos, motorPos;
	logic signed [POS_W-1:0] posRefOut, speedFfOut, torqueFfOut;
	int errorCnt, samplesChecked;

	svs_vib_suppress dut_u (.clk, .resetn, .trqIn, .trqInValid, .trqInReady, .spdDev,
		.trqOut, .trqOutValid, .trqOutReady, .notch1_freq, .notch1_depth, .notch1_width,
		.notch2_freq, .notch2_depth, .notch2_width, .notch3_freq, .notch3_depth,
		.notch3_width, .if_center_freq, .if_bandwidth, .if_suppression, .if_lowpass_time,
		.if_highpass_time, .if_damping, .model_follow_select, .load_osc_freq,
		.load_osc_filter_time, .load_osc_limit, .posCtrlMode, .manualTuning, .fullyClosed,
		.posRefIn, .speedFfIn, .torqueFfIn, .loadPos, .motorPos, .posRefOut, .speedFfOut,
		.torqueFfOut, .losActive, .auto_vib_enable, .vib_amplitude_threshold, .detValid,
		.detFreq, .detAmp, .vibDetected, .autoNotchSet, .autoIfSet, .autoFreq);
	svs_torque_sink sink_u (.clk, .trqOut, .trqOutValid, .trqOutReady, .stall);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic printVerdict;
		if (errorCnt == 0 && samplesChecked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Selectors are only read at the first edge after release
	task automatic do_reset(input logic [1:0] mf, input logic av);
		@(negedge clk);
		resetn = 1'b0;
		model_follow_select = mf;
		auto_vib_enable = av;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		repeat (2) @(negedge clk);
	endtask

	// Valid stays up so callers can stream back to back
	task automatic push(input logic signed [15:0] v);
		int k = 0;
		trqIn = v;
		spdDev = 16'sh0300;
		trqInValid = 1'b1;
		while (trqInReady !== 1'b1 && k < 100) begin
			@(negedge clk);
			k++;
		end
		@(negedge clk);
	endtask

	task automatic wait_got(input int n);
		int k = 0;
		while (sink_u.got.size() < n && k < 200) begin
			@(negedge clk);
			k++;
		end
		`CHK("words out", n, sink_u.got.size())
	endtask

	// Four equal words through; counts outputs that differ from the input
	task automatic stream(input logic signed [15:0] x, output int nd);
		nd = 0;
		sink_u.got.delete();
		repeat (4) push(x);
		trqInValid = 1'b0;
		wait_got(4);
		foreach (sink_u.got[i])
			if (sink_u.got[i] !== x)
				nd++;
	endtask

	task automatic t_bypass;
		logic signed [15:0] v[4] = '{16'sh1234, -16'sh0005, 16'sh7fff, -16'sh8000};
		sink_u.got.delete();
		foreach (v[i]) push(v[i]);
		trqInValid = 1'b0;
		wait_got(4);
		foreach (v[i]) `CHK("bypass word", v[i], sink_u.got[i])
	endtask

	task automatic t_stall;
		int taken = 0;
		logic hit;
		sink_u.got.delete();
		stall = 1'b1;
		trqIn = 16'sh0100;
		trqInValid = 1'b1;
		for (int k = 0; k < 80 && taken < 8; k++) begin
			// Ready seen off the edge is what the next rising edge samples
			hit = (trqInReady === 1'b1);
			@(negedge clk);
			if (hit)
				taken++;
			if (k == 20) begin
				`CHK("refused while full", 1'b0, trqInReady)
				`CHK("held back", 0, sink_u.got.size())
				stall = 1'b0;
			end
			trqIn = 16'sh0100 + 16'(taken);
		end
		trqInValid = 1'b0;
		wait_got(8);
		for (int i = 0; i < 8; i++)
			`CHK("order kept", 16'sh0100 + 16'(i), sink_u.got[i])
	endtask

	// Fresh filter state, so a live notch or IF term must show in the words
	task automatic t_filters;
		int nd;
		do_reset(MF_OFF, 1'b0);
		notch1_freq = 16'h01f4;
		stream(16'sh1000, nd);
		`CHK("notch cut", 1'b1, nd > 0)
		notch1_depth = 5'h1f;
		repeat (2) @(negedge clk);
		`CHK("depth kept", DEPTH_MAX, dut_u.depth_q[0])
		{notch1_freq, notch1_depth} = {NOTCH_OFF, 5'h17};
		if_center_freq = 16'h0063;
		stream(16'sh0400, nd);
		`CHK("IF below band", 0, nd)
		if_center_freq = 16'h01f4;
		stream(16'sh0400, nd);
		`CHK("IF comp added", 1'b1, nd > 0)
		if_center_freq = IF_OFF;
	endtask

	task automatic los_check(input logic exp);
		repeat (3) @(negedge clk);
		`CHK("load active", exp, losActive)
	endtask

	task automatic t_los;
		do_reset(MF_ON, 1'b0);
		for (int i = 0; i < 3; i++) push(16'sh0010);
		trqInValid = 1'b0;
		los_check(1'b0);
		`CHK("ref untouched", posRefIn, posRefOut)
		model_follow_select = MF_LOS;
		los_check(1'b0);
		do_reset(MF_LOS, 1'b0);
		los_check(1'b1);
		for (int i = 0; i < 8; i++) push(16'sh0010);
		trqInValid = 1'b0;
		repeat (3) @(negedge clk);
		// Load far ahead of the motor, so the correction sits at the limit
		`CHK("ref clamp", load_osc_limit, posRefIn - posRefOut)
		`CHK("speed ff corr", load_osc_limit, speedFfIn - speedFfOut)
		`CHK("torque ff corr", load_osc_limit, torqueFfIn - torqueFfOut)
		fullyClosed = 1'b1;
		los_check(1'b0);
		`CHK("ref released", posRefIn, posRefOut)
		fullyClosed = 1'b0;
		posCtrlMode = 1'b0;
		los_check(1'b0);
		posCtrlMode = 1'b1;
		manualTuning = 1'b0;
		los_check(1'b0);
		manualTuning = 1'b1;
		los_check(1'b1);
	endtask

	task automatic detect(input logic [15:0] f, input logic [15:0] a, input logic hit,
		input logic toIf);
		detFreq = f;
		detAmp = a;
		detValid = 1'b1;
		@(negedge clk);
		detValid = 1'b0;
		`CHK("detect pulse", hit, vibDetected)
		if (hit) begin
			`CHK("if chosen", toIf, autoIfSet)
			`CHK("notch chosen", !toIf, autoNotchSet)
			`CHK("auto freq", f, autoFreq)
		end
		@(negedge clk);
		`CHK("pulse end", 1'b0, vibDetected)
	endtask

	task automatic t_detect;
		vib_amplitude_threshold = 16'h0100;
		do_reset(MF_OFF, 1'b0);
		detect(16'h01f4, 16'h0200, 1'b0, 1'b0);
		do_reset(MF_OFF, 1'b1);
		detect(16'h01f4, 16'h0100, 1'b0, 1'b0);
		detect(16'h01f4, 16'h0101, 1'b1, 1'b1);
		detect(16'h0bb8, 16'h0200, 1'b1, 1'b0);
		detect(16'h0064, 16'h0200, 1'b1, 1'b1);
		detect(16'h07d0, 16'h0200, 1'b1, 1'b0);
	endtask

	initial begin
		#300000;
		errorCnt++;
		printVerdict;
	end

	initial begin
		{resetn, stall, trqInValid, detValid, trqIn, spdDev, detFreq, detAmp} = '0;
		{notch1_freq, notch2_freq, notch3_freq} = {3{NOTCH_OFF}};
		{notch1_depth, notch2_depth, notch3_depth} = {5'h17, 5'h00, 5'h0c};
		{notch1_width, notch2_width, notch3_width} = {4'hf, 4'h0, 4'h7};
		if_center_freq = IF_OFF;
		{if_bandwidth, if_suppression, if_damping} = {16'h0040, 16'h0080, 16'h0100};
		{if_lowpass_time, if_highpass_time, load_osc_freq} = {16'h0003, 16'h0005, 16'h0064};
		load_osc_filter_time = 16'h0002;
		load_osc_limit = 32'h0000_0010;
		{posCtrlMode, manualTuning, fullyClosed} = 3'b110;
		{posRefIn, speedFfIn, torqueFfIn} = {32'sh0000_1000, 32'sh0000_0200, 32'sh0000_0080};
		loadPos = 32'sh0010_0000;
		motorPos = 32'sh0000_0000;
		model_follow_select = MF_OFF;
		auto_vib_enable = 1'b0;
		vib_amplitude_threshold = 16'hffff;
		errorCnt = 0;
		samplesChecked = 0;
		do_reset(MF_OFF, 1'b0);
		t_bypass();
		t_stall();
		t_filters();
		t_los();
		t_detect();
		printVerdict;
	end
endmodule
